// File: bca_consts.svh
`ifndef BCA_CONSTS_SVH
`define BCA_CONSTS_SVH
// ------------------------------------------------------------
// opcode bytes
// ------------------------------------------------------------
`define BCA_OP_ADD_ADJ 8'h37
`define BCA_OP_SUB_ADJ 8'h3f
`define BCA_OP_MUL_ADJ 8'hd4
`define BCA_OP_DIV_PREP 8'hd5
`define BCA_OP_ADC_RM8_R8 8'h10
`define BCA_OP_ADC_RM_R 8'h11
`define BCA_OP_ADC_R8_RM8 8'h12
`define BCA_OP_ADC_R_RM 8'h13
`define BCA_OP_ADC_ACC8_IMM 8'h14
`define BCA_OP_ADC_ACC_IMM 8'h15
`define BCA_OP_GRP_BYTE_IMMEDIATE 8'h80
`define BCA_OP_GRP_IMM 8'h81
`define BCA_OP_GRP_SIMM8 8'h83
// ------------------------------------------------------------
// fields and figures
// ------------------------------------------------------------
`define BCA_REG_LSB 3
`define BCA_REG_MSB 5
`define BCA_REG_ADC 3'h2
`define BCA_NIB_MAX 4'h9
`define BCA_ADJ_STEP 8'h06
`define BCA_LOW_NIB 8'h0f
`define BCA_SHAMT_B 6'h18
`define BCA_SHAMT_W 6'h10
`define BCA_SHAMT_D 6'h00
`endif

// File: bca_pkg.sv
package bca_pkg;
    // ------------------------------------------------------------
    // operand width of an add_with_carry
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_DWORD
    } bca_size_e;
    // ------------------------------------------------------------
    // where the result must be written back
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WR_NONE,
        WR_ACC,
        WR_RM,
        WR_REG
    } bca_target_e;
    // ------------------------------------------------------------
    // decoded operation
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        K_NONE,
        K_ADD_ADJ,
        K_SUB_ADJ,
        K_DIV_PREP,
        K_MUL_ADJ,
        K_ADC
    } bca_kind_e;
endpackage : bca_pkg

// File: bca_alu.sv
// Operation
// RULE1 - opcode 37 is add adjust on low byte
// RULE2 - decimal carry: add 6, bump high, set flags
// RULE3 - no carry: clear both flags, high kept
// RULE4 - add adjust clears upper nibble of low
// RULE5 - other flags undefined after add/sub adjust
// RULE6 - bytes d5 0a are division prep
// RULE7 - low gets low+high*imm, high cleared
// RULE8 - immediate is second byte, any value honoured
// RULE9 - div/mul adjust set sign, zero, parity
// RULE10 - bytes d4 0a are multiply adjust
// RULE11 - high gets quotient, low gets remainder
// RULE12 - opcode 3f is sub adjust on low byte
// RULE13 - decimal borrow: subtract 6, drop high, set flags
// RULE14 - no borrow: clear flags; upper nibble zeroed
// RULE15 - add_with_carry immediate forms 14 15 80/81/83 /2
// RULE16 - forms 10 11 write rm, 12 13 write reg
// RULE17 - destination plus source plus carry, written back
// RULE18 - narrow immediate sign-extended to destination width
// RULE19 - carry, overflow, sign, zero, aux, parity from sum
// RULE20 - zero on zero result, parity on even low byte
`include "bca_consts.svh"

module bca_alu
    import bca_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // instruction from the decoder
    input wire logic op_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] op_byte2,
    input wire bca_size_e op_size,
    input wire logic [31:0] imm_in,
    // operands from the register file
    input wire logic [31:0] acc_in,
    input wire logic [31:0] rm_in,
    input wire logic [31:0] reg_in,
    // current flags
    input wire logic cf_in,
    input wire logic af_in,
    input wire logic of_in,
    input wire logic sf_in,
    input wire logic zf_in,
    input wire logic pf_in,
    // result back to the register file
    output logic res_valid,
    output logic [31:0] result_q,
    output bca_target_e wr_target_q,
    output bca_size_e wr_size_q,
    output logic bad_op_q,
    output logic div_err_q,
    // new flags
    output logic cf_q,
    output logic af_q,
    output logic of_q,
    output logic sf_q,
    output logic zf_q,
    output logic pf_q
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    bca_kind_e kind; // decoded operation
    bca_target_e tgt; // write-back target
    bca_size_e sz; // effective operand width
    logic [31:0] a_op; // destination operand
    logic [31:0] b_op; // source operand, extended
    logic [2:0] reg_fld; // reg field of the second byte

    assign reg_fld = op_byte2[`BCA_REG_MSB:`BCA_REG_LSB];

    // opcode to kind, target, width and operands
    always_comb begin
        kind = K_NONE;
        tgt = WR_NONE;
        sz = op_size;
        a_op = acc_in;
        b_op = reg_in;
        unique case (opcode)
            `BCA_OP_ADD_ADJ: kind = K_ADD_ADJ; // see RULE1
            `BCA_OP_SUB_ADJ: kind = K_SUB_ADJ; // see RULE12
            `BCA_OP_DIV_PREP: kind = K_DIV_PREP; // see RULE6
            `BCA_OP_MUL_ADJ: kind = K_MUL_ADJ; // see RULE10
            `BCA_OP_ADC_RM8_R8, `BCA_OP_ADC_RM_R: begin
                // register-or-memory is the destination
                kind = K_ADC; // see RULE16
                tgt = WR_RM;
                a_op = rm_in;
                sz = (opcode == `BCA_OP_ADC_RM8_R8) ? SZ_BYTE : op_size;
            end
            `BCA_OP_ADC_R8_RM8, `BCA_OP_ADC_R_RM: begin
                // register is the destination
                kind = K_ADC; // see RULE16
                tgt = WR_REG;
                a_op = reg_in;
                b_op = rm_in;
                sz = (opcode == `BCA_OP_ADC_R8_RM8) ? SZ_BYTE : op_size;
            end
            `BCA_OP_ADC_ACC8_IMM, `BCA_OP_ADC_ACC_IMM: begin
                kind = K_ADC; // see RULE15
                tgt = WR_ACC;
                b_op = imm_in;
                sz = (opcode == `BCA_OP_ADC_ACC8_IMM) ? SZ_BYTE : op_size;
            end
            `BCA_OP_GRP_BYTE_IMMEDIATE, `BCA_OP_GRP_IMM, `BCA_OP_GRP_SIMM8: begin
                // only reg field 2 belongs here; others are not ours
                if (reg_fld == `BCA_REG_ADC) begin
                    kind = K_ADC; // see RULE15
                    tgt = WR_RM;
                    a_op = rm_in;
                    b_op = imm_in;
                    sz = (opcode == `BCA_OP_GRP_BYTE_IMMEDIATE) ? SZ_BYTE : op_size;
                    if (opcode == `BCA_OP_GRP_SIMM8) begin
                        // byte immediate into a wider destination
                        b_op = {{24{imm_in[7]}}, imm_in[7:0]}; // see RULE18
                    end
                end
            end
            default: kind = K_NONE;
        endcase
        // the adjust operations all work on the accumulator word
        if (kind inside {K_ADD_ADJ, K_SUB_ADJ, K_DIV_PREP, K_MUL_ADJ}) begin
            tgt = WR_ACC;
            sz = SZ_WORD;
        end
    end

    // ------------------------------------------------------------
    // add_with_carry datapath
    // ------------------------------------------------------------
    // operands are shifted so their top bit sits at bit 31; one adder
    // then serves all three widths and carry/overflow land in fixed bits
    logic [5:0] shamt; // left alignment for the width
    logic [31:0] a_al; // aligned destination
    logic [31:0] b_al; // aligned source
    logic [31:0] c_al; // aligned carry in
    logic [32:0] sum_al; // aligned sum with carry out
    logic [31:0] adc_res; // sum at true position

    assign shamt = (sz == SZ_BYTE) ? `BCA_SHAMT_B :
        (sz == SZ_WORD) ? `BCA_SHAMT_W : `BCA_SHAMT_D;

    assign a_al = a_op << shamt;
    assign b_al = b_op << shamt;
    assign c_al = {31'h0, cf_in} << shamt;
    assign sum_al = {1'b0, a_al} + {1'b0, b_al} + {1'b0, c_al}; // see RULE17
    assign adc_res = sum_al[31:0] >> shamt;

    // ------------------------------------------------------------
    // bcd adjust datapath
    // ------------------------------------------------------------
    logic [7:0] al; // accumulator low byte
    logic [7:0] ah; // accumulator high byte
    logic dec_carry; // nibble above nine or aux carry set
    logic [7:0] prep_al; // division prep low byte
    logic [7:0] mul_q; // multiply adjust quotient
    logic [7:0] mul_r; // multiply adjust remainder
    logic imm_zero; // divisor of zero for multiply adjust

    assign al = acc_in[7:0];
    assign ah = acc_in[15:8];
    assign dec_carry = (al[3:0] > `BCA_NIB_MAX) || af_in;
    // the product is cut to eight bits on purpose
    assign prep_al = 8'(al + ah * op_byte2); // see RULE7 RULE8
    assign imm_zero = (op_byte2 == 8'h00);
    // divider is only meaningful with a non-zero second byte
    assign mul_q = imm_zero ? 8'h00 : al / op_byte2; // see RULE11
    assign mul_r = imm_zero ? 8'h00 : al % op_byte2;

    // ------------------------------------------------------------
    // result and flags for the chosen operation
    // ------------------------------------------------------------
    logic [31:0] res_d; // value to write
    bca_target_e tgt_d; // target after error checks
    logic cf_d, af_d, of_d, sf_d, zf_d, pf_d; // next flags

    always_comb begin
        res_d = acc_in;
        tgt_d = tgt;
        // flags left undefined by an operation keep their old value; see RULE5
        {cf_d, af_d, of_d, sf_d, zf_d, pf_d} = {cf_in, af_in, of_in, sf_in, zf_in, pf_in};
        unique case (kind)
            K_ADD_ADJ, K_SUB_ADJ: begin
                // add adjust carries into the high byte, sub adjust borrows from it
                if (dec_carry) begin
                    res_d[7:0] = ((kind == K_ADD_ADJ) ? al + `BCA_ADJ_STEP
                        : al - `BCA_ADJ_STEP) & `BCA_LOW_NIB; // see RULE2 RULE13
                    res_d[15:8] = (kind == K_ADD_ADJ) ? ah + 8'h01 : ah - 8'h01;
                end else begin
                    res_d[7:0] = al & `BCA_LOW_NIB; // see RULE3 RULE14
                end
                // upper nibble is dropped on both paths; see RULE4
                cf_d = dec_carry;
                af_d = dec_carry;
            end
            K_DIV_PREP, K_MUL_ADJ: begin
                res_d[15:0] = (kind == K_DIV_PREP) ? {8'h00, prep_al}
                    : {mul_q, mul_r}; // see RULE7 RULE11
                if (kind == K_MUL_ADJ && imm_zero) begin
                    // divide by zero: nothing written, flags kept
                    tgt_d = WR_NONE;
                end else begin
                    sf_d = res_d[7]; // see RULE9
                    zf_d = (res_d[7:0] == 8'h00);
                    pf_d = ~^res_d[7:0];
                end
            end
            K_ADC: begin
                res_d = adc_res; // see RULE17
                cf_d = sum_al[32]; // see RULE19
                of_d = (a_al[31] == b_al[31]) && (sum_al[31] != a_al[31]);
                sf_d = sum_al[31];
                zf_d = (adc_res == 32'h0); // see RULE20
                af_d = a_op[4] ^ b_op[4] ^ adc_res[4];
                pf_d = ~^adc_res[7:0]; // see RULE20
            end
            default: tgt_d = WR_NONE;
        endcase
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // answer one cycle after the request, one pulse per request
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            {res_valid, bad_op_q, div_err_q} <= 3'h0;
        end else begin
            res_valid <= op_valid;
            bad_op_q <= op_valid && (kind == K_NONE);
            div_err_q <= op_valid && (kind == K_MUL_ADJ) && imm_zero;
        end
    end

    // result, target and flags hold until the next request
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            result_q <= 32'h0;
            wr_target_q <= WR_NONE;
            wr_size_q <= SZ_BYTE;
            {cf_q, af_q, of_q, sf_q, zf_q, pf_q} <= 6'h00;
        end else if (op_valid) begin
            result_q <= res_d;
            wr_target_q <= tgt_d;
            wr_size_q <= sz;
            {cf_q, af_q, of_q, sf_q, zf_q, pf_q} <= {cf_d, af_d, of_d, sf_d, zf_d, pf_d};
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_add_adj_carry;
        @(posedge clk_sys) disable iff (!resetn)
        op_valid && opcode == `BCA_OP_ADD_ADJ && dec_carry |=>
            cf_q && af_q && wr_target_q == WR_ACC &&
            result_q[15:8] == $past(ah) + 8'h01 &&
            result_q[3:0] == 4'($past(al) + 8'h06);
    endproperty
    a_add_adj_carry: assert property (p_add_adj_carry) // see RULE2
        else $error("add adjust carry path wrong");
    property p_add_adj_plain;
        @(posedge clk_sys) disable iff (!resetn)
        op_valid && opcode == `BCA_OP_ADD_ADJ && !dec_carry |=>
            !cf_q && !af_q && result_q[15:8] == $past(ah);
    endproperty
    a_add_adj_plain: assert property (p_add_adj_plain) // see RULE3
        else $error("add adjust plain path wrong");
    property p_adj_upper_zero;
        @(posedge clk_sys) disable iff (!resetn)
        op_valid && (opcode == `BCA_OP_ADD_ADJ || opcode == `BCA_OP_SUB_ADJ) |=>
            result_q[7:4] == 4'h0;
    endproperty
    a_adj_upper_zero: assert property (p_adj_upper_zero) // see RULE4
        else $error("adjust left upper nibble set");
    property p_sub_adj;
        @(posedge clk_sys) disable iff (!resetn)
        op_valid && opcode == `BCA_OP_SUB_ADJ |=>
            cf_q == $past(dec_carry) && af_q == cf_q &&
            result_q[15:8] == $past(ah) - {7'h0, cf_q};
    endproperty
    a_sub_adj: assert property (p_sub_adj) // see RULE13
        else $error("sub adjust borrow wrong");
    property p_div_prep;
        @(posedge clk_sys) disable iff (!resetn)
        op_valid && opcode == `BCA_OP_DIV_PREP |=>
            result_q[15:0] == {8'h00, 8'($past(al) + $past(ah) * $past(op_byte2))} &&
            zf_q == (result_q[7:0] == 8'h00);
    endproperty
    a_div_prep: assert property (p_div_prep) // see RULE7
        else $error("division prep result wrong");
    property p_mul_adj;
        @(posedge clk_sys) disable iff (!resetn)
        op_valid && opcode == `BCA_OP_MUL_ADJ && !imm_zero |=>
            result_q[15:8] * $past(op_byte2) + result_q[7:0] == 16'($past(al)) &&
            result_q[7:0] < $past(op_byte2) && sf_q == result_q[7];
    endproperty
    a_mul_adj: assert property (p_mul_adj) // see RULE11
        else $error("multiply adjust split wrong");
    property p_adc_acc8;
        @(posedge clk_sys) disable iff (!resetn)
        op_valid && opcode == `BCA_OP_ADC_ACC8_IMM |=>
            {cf_q, result_q[7:0]} ==
                9'($past(al)) + 9'($past(imm_in[7:0])) + 9'($past(cf_in));
    endproperty
    a_adc_acc8: assert property (p_adc_acc8) // see RULE17
        else $error("byte add with carry wrong");
    property p_adc_sext;
        @(posedge clk_sys) disable iff (!resetn)
        op_valid && opcode == `BCA_OP_GRP_SIMM8 && reg_fld == `BCA_REG_ADC &&
            op_size == SZ_DWORD |=>
            result_q == 32'($past(rm_in) + {{24{$past(imm_in[7])}}, $past(imm_in[7:0])}
                + 32'($past(cf_in))) && wr_target_q == WR_RM;
    endproperty
    a_adc_sext: assert property (p_adc_sext) // see RULE18
        else $error("sign-extended immediate sum wrong");
    property p_adc_target;
        @(posedge clk_sys) disable iff (!resetn)
        op_valid && opcode[7:2] == 6'h04 |=>
            wr_target_q == ($past(opcode[1]) ? WR_REG : WR_RM);
    endproperty
    a_adc_target: assert property (p_adc_target) // see RULE16
        else $error("add with carry target wrong");
    property p_adc_flags;
        @(posedge clk_sys) disable iff (!resetn)
        op_valid && kind == K_ADC |=>
            pf_q == ~^result_q[7:0] && zf_q == (result_q == 32'h0);
    endproperty
    a_adc_flags: assert property (p_adc_flags) // see RULE20
        else $error("zero or parity flag wrong");

endmodule : bca_alu

// File: bca_rf_model.sv
// ------------------------------------------------------------
// register file model: takes the alu write-back into its lanes
// ------------------------------------------------------------
module bca_rf_model
    import bca_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // write-back from the alu
    input wire logic res_valid,
    input wire logic [31:0] result_q,
    input wire bca_target_e wr_target_q,
    input wire bca_size_e wr_size_q,
    // stored operands
    output logic [31:0] acc_q,
    output logic [31:0] rm_q,
    output logic [31:0] reg_q
);
    logic [31:0] keep_mask; // lanes that a narrow write leaves alone

    // a byte or word write must not disturb the upper lanes
    always_comb begin
        case (wr_size_q)
            SZ_BYTE: keep_mask = 32'hffffff00;
            SZ_WORD: keep_mask = 32'hffff0000;
            default: keep_mask = 32'h00000000;
        endcase
    end

    // write-back lands only on the target named by the alu
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            acc_q <= 32'h00000000;
            rm_q <= 32'h00000000;
            reg_q <= 32'h00000000;
        end else if (res_valid) begin
            case (wr_target_q)
                WR_ACC: acc_q <= (acc_q & keep_mask) | (result_q & ~keep_mask);
                WR_RM: rm_q <= (rm_q & keep_mask) | (result_q & ~keep_mask);
                WR_REG: reg_q <= (reg_q & keep_mask) | (result_q & ~keep_mask);
                default: ; // no write for refused operations
            endcase
        end
    end
endmodule : bca_rf_model

// File: bca_tb.sv
module testbench
    import bca_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic op_valid = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [7:0] op_byte2 = 8'h00;
    bca_size_e op_size = SZ_BYTE;
    logic [31:0] imm_in = 32'h0, acc_in = 32'h0, rm_in = 32'h0, reg_in = 32'h0;
    logic [5:0] fl_in = 6'h00; // cf af of sf zf pf
    logic res_valid, bad_op_q, div_err_q, cf_q, af_q, of_q, sf_q, zf_q, pf_q;
    logic [31:0] result_q, acc_q, rm_q, reg_q;
    bca_target_e wr_target_q;
    bca_size_e wr_size_q;
    int n_fail = 0;
    int cmp_count = 0;

    always #2.5 clk_sys = ~clk_sys;

    bca_alu u_bca_alu (.clk_sys(clk_sys), .resetn(resetn), .op_valid(op_valid),
        .opcode(opcode), .op_byte2(op_byte2), .op_size(op_size), .imm_in(imm_in),
        .acc_in(acc_in), .rm_in(rm_in), .reg_in(reg_in), .cf_in(fl_in[5]), .af_in(fl_in[4]),
        .of_in(fl_in[3]), .sf_in(fl_in[2]), .zf_in(fl_in[1]), .pf_in(fl_in[0]),
        .res_valid(res_valid), .result_q(result_q), .wr_target_q(wr_target_q),
        .wr_size_q(wr_size_q), .bad_op_q(bad_op_q), .div_err_q(div_err_q), .cf_q(cf_q),
        .af_q(af_q), .of_q(of_q), .sf_q(sf_q), .zf_q(zf_q), .pf_q(pf_q));

    bca_rf_model u_bca_rf_model (.clk_sys(clk_sys), .resetn(resetn), .res_valid(res_valid),
        .result_q(result_q), .wr_target_q(wr_target_q), .wr_size_q(wr_size_q),
        .acc_q(acc_q), .rm_q(rm_q), .reg_q(reg_q));

    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    // called just after an edge; the request is taken at the next one
    task automatic drive(input logic [7:0] opc, input logic [7:0] b2, input bca_size_e sz,
        input logic [31:0] imm, input logic [31:0] a, input logic [31:0] rm,
        input logic [31:0] rg, input logic [5:0] fl);
        op_valid <= 1'b1;
        opcode <= opc;
        op_byte2 <= b2;
        op_size <= sz;
        imm_in <= imm;
        acc_in <= a;
        rm_in <= rm;
        reg_in <= rg;
        fl_in <= fl;
    endtask : drive

    // one operation; returns with the answer settled on the outputs
    task automatic run(input logic [7:0] opc, input logic [7:0] b2, input bca_size_e sz,
        input logic [31:0] imm, input logic [31:0] a, input logic [31:0] rm,
        input logic [31:0] rg, input logic [5:0] fl);
        @(posedge clk_sys);
        drive(opc, b2, sz, imm, a, rm, rg, fl);
        @(posedge clk_sys);
        op_valid <= 1'b0;
        #1;
        chk_flag(res_valid, 1'b1);
    endtask : run

    // ------------------------------------------------------------
    // reference arithmetic kept apart from the design
    // ------------------------------------------------------------
    function automatic logic [37:0] adc_ref(input int w, input logic [31:0] m,
        input logic [31:0] a, input logic [31:0] b, input logic c);
        logic [32:0] s;
        logic [31:0] r;
        s = {1'b0, a & m} + {1'b0, b & m} + {32'h0, c};
        r = s[31:0] & m;
        return {s[w + 1], (a[w] == b[w]) && (r[w] != a[w]), r[w], r == 32'h0,
            a[4] ^ b[4] ^ r[4], ~^r[7:0], r};
    endfunction : adc_ref

    // decimal adjust; e is {cf,af} for 37/3f and {sf,zf,pf} for d4/d5
    task automatic bcd_case(input logic [7:0] opc, input logic [7:0] b2, input logic [15:0] a,
        input logic af, input logic [15:0] exp, input logic [2:0] e);
        run(opc, b2, SZ_WORD, 32'h0, {16'h1234, a}, 32'h0, 32'h0, {1'b0, af, 4'h0});
        chk_val({16'h0, result_q[15:0]}, {16'h0, exp});
        chk_val(32'(wr_target_q), 32'(WR_ACC));
        if (opc == 8'h37 || opc == 8'h3f) begin
            chk_val({30'h0, cf_q, af_q}, {30'h0, e[1:0]});
        end else begin
            chk_val({29'h0, sf_q, zf_q, pf_q}, {29'h0, e});
        end
    endtask : bcd_case

    // add_with_carry in any form, checked at the ports and in the register file
    task automatic adc_case(input logic [7:0] opc, input bca_size_e sz, input logic [31:0] imm,
        input logic [31:0] a, input logic [31:0] rm, input logic [31:0] rg, input logic c);
        logic [31:0] dst, src, m;
        bca_size_e es;
        bca_target_e et;
        logic [37:0] e;
        int w;
        es = opc[0] ? sz : SZ_BYTE;
        w = (es == SZ_BYTE) ? 7 : (es == SZ_WORD) ? 15 : 31;
        m = (es == SZ_BYTE) ? 32'hff : (es == SZ_WORD) ? 32'hffff : 32'hffffffff;
        case (opc)
            8'h14, 8'h15: begin
                dst = a;
                src = imm;
                et = WR_ACC;
            end
            8'h80, 8'h81, 8'h10, 8'h11: begin
                dst = rm;
                src = (opc[7]) ? imm : rg;
                et = WR_RM;
            end
            8'h83: begin
                dst = rm;
                src = {{24{imm[7]}}, imm[7:0]};
                et = WR_RM;
            end
            default: begin
                dst = rg;
                src = rm;
                et = WR_REG;
            end
        endcase
        e = adc_ref(w, m, dst, src, c);
        run(opc, 8'h10, sz, imm, a, rm, rg, {c, 5'h00});
        chk_val(result_q & m, e[31:0]);
        chk_val({26'h0, cf_q, of_q, sf_q, zf_q, af_q, pf_q}, {26'h0, e[37:32]});
        chk_val({28'h0, wr_target_q, wr_size_q}, {28'h0, et, es});
        @(posedge clk_sys);
        #1;
        chk_val(((et == WR_ACC) ? acc_q : (et == WR_RM) ? rm_q : reg_q) & m, e[31:0]);
    endtask : adc_case

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_add_adj();
        bcd_case(8'h37, 8'h0a, 16'h000b, 1'b0, 16'h0101, 3'h3);
        bcd_case(8'h37, 8'h0a, 16'h0203, 1'b1, 16'h0309, 3'h3);
        bcd_case(8'h37, 8'h0a, 16'h0539, 1'b0, 16'h0509, 3'h0);
        bcd_case(8'h37, 8'h0a, 16'hff0f, 1'b0, 16'h0005, 3'h3);
    endtask : t_add_adj

    task automatic t_sub_adj();
        bcd_case(8'h3f, 8'h0a, 16'h0302, 1'b1, 16'h020c, 3'h3);
        bcd_case(8'h3f, 8'h0a, 16'h000a, 1'b0, 16'hff04, 3'h3);
        bcd_case(8'h3f, 8'h0a, 16'h0758, 1'b0, 16'h0708, 3'h0);
    endtask : t_sub_adj

    task automatic t_div_mul();
        bcd_case(8'hd5, 8'h0a, 16'h0705, 1'b0, 16'h004b, 3'h1);
        bcd_case(8'hd5, 8'h07, 16'h0304, 1'b0, 16'h0019, 3'h0);
        bcd_case(8'hd5, 8'hff, 16'hffff, 1'b0, 16'h0000, 3'h3);
        bcd_case(8'hd5, 8'h0a, 16'h0980, 1'b0, 16'h00da, 3'h4);
        bcd_case(8'hd4, 8'h0a, 16'h0041, 1'b0, 16'h0605, 3'h1);
        bcd_case(8'hd4, 8'h10, 16'h00ff, 1'b0, 16'h0f0f, 3'h1);
        bcd_case(8'hd4, 8'h0a, 16'h0050, 1'b0, 16'h0800, 3'h3);
        bcd_case(8'hd4, 8'hf1, 16'h00f0, 1'b0, 16'h00f0, 3'h5);
    endtask : t_div_mul

    task automatic t_adc_forms();
        adc_case(8'h14, SZ_BYTE, 32'h01, 32'hff, 32'h0, 32'h0, 1'b1);
        adc_case(8'h15, SZ_WORD, 32'h0, 32'h7fff, 32'h0, 32'h0, 1'b1);
        adc_case(8'h15, SZ_DWORD, 32'hffffffff, 32'h1, 32'h0, 32'h0, 1'b0);
        adc_case(8'h80, SZ_DWORD, 32'h7f, 32'h0, 32'h12345601, 32'h0, 1'b0);
        adc_case(8'h81, SZ_WORD, 32'h8000, 32'h0, 32'h8000, 32'h0, 1'b1);
        adc_case(8'h83, SZ_DWORD, 32'hfe, 32'h0, 32'h10, 32'h0, 1'b0);
        adc_case(8'h83, SZ_WORD, 32'h80, 32'h0, 32'h5, 32'h0, 1'b1);
        adc_case(8'h10, SZ_DWORD, 32'h0, 32'h0, 32'hf0, 32'h0f, 1'b1);
        adc_case(8'h11, SZ_DWORD, 32'h0, 32'h0, 32'h7fffffff, 32'h0, 1'b1);
        adc_case(8'h12, SZ_BYTE, 32'h0, 32'h0, 32'h08, 32'h08, 1'b0);
        adc_case(8'h13, SZ_WORD, 32'h0, 32'h0, 32'h4321, 32'h1234, 1'b1);
    endtask : t_adc_forms

    // other reg fields of 80 and 83 and a zero divisor write nothing
    task automatic t_refused();
        run(8'h80, 8'h00, SZ_BYTE, 32'h1, 32'h0, 32'h5, 32'h0, 6'h0);
        chk_flag(bad_op_q, 1'b1);
        chk_val(32'(wr_target_q), 32'(WR_NONE));
        run(8'h83, 8'h38, SZ_WORD, 32'h1, 32'h0, 32'h5, 32'h0, 6'h0);
        chk_flag(bad_op_q, 1'b1);
        run(8'hd4, 8'h00, SZ_WORD, 32'h0, 32'h0041, 32'h0, 32'h0, 6'h0);
        chk_flag(div_err_q, 1'b1);
        chk_val(32'(wr_target_q), 32'(WR_NONE));
        @(posedge clk_sys);
        #1;
        chk_flag(div_err_q, 1'b0);
    endtask : t_refused

    // two requests on consecutive edges give two answers on consecutive edges
    task automatic t_back_to_back();
        @(posedge clk_sys);
        drive(8'h37, 8'h0a, SZ_WORD, 32'h0, 32'h000b, 32'h0, 32'h0, 6'h00);
        @(posedge clk_sys);
        drive(8'h14, 8'h10, SZ_BYTE, 32'h01, 32'hff, 32'h0, 32'h0, 6'h20);
        #1;
        chk_val({16'h0, result_q[15:0]}, 32'h0101);
        @(posedge clk_sys);
        op_valid <= 1'b0;
        #1;
        chk_flag(res_valid, 1'b1);
        chk_val({24'h0, result_q[7:0]}, 32'h01);
        @(posedge clk_sys);
        #1;
        chk_flag(res_valid, 1'b0);
    endtask : t_back_to_back

    // ------------------------------------------------------------
    // verdict, main sequence and watchdog
    // ------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk_flag(res_valid, 1'b0);
        chk_val(32'(wr_target_q), 32'(WR_NONE));
        t_add_adj();
        t_sub_adj();
        t_div_mul();
        t_adc_forms();
        t_refused();
        t_back_to_back();
        summarize();
    end

    // the whole run needs about 80 cycles; this bound cuts a hang
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        summarize();
    end
endmodule : testbench
